// *** fiq_ctrl.sv ***
// Purpose: Fast interrupt vector, nesting status and external trigger control
// Assumes: AXI4-Lite slave, one write and one read at a time
// Notes: Source requests and priorities of internal sources come from outside
//
// ==========================================================
module fiq_ctrl
    import fiq_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axil_awaddr,
    input wire logic s_axil_awvalid,
    output logic s_axil_awready,
    input wire logic [31:0] s_axil_wdata,
    input wire logic [3:0] s_axil_wstrb,
    input wire logic s_axil_wvalid,
    output logic s_axil_wready,
    output logic [1:0] s_axil_bresp,
    output logic s_axil_bvalid,
    input wire logic s_axil_bready,
    input wire logic [31:0] s_axil_araddr,
    input wire logic s_axil_arvalid,
    output logic s_axil_arready,
    output logic [31:0] s_axil_rdata,
    output logic [1:0] s_axil_rresp,
    output logic s_axil_rvalid,
    input wire logic s_axil_rready,
    input wire logic [NSRC-1:0] src_req,
    input wire logic [NSRC-1:0][PRIW-1:0] src_prio,
    input wire logic [NEXT-1:0] ext_int_in,
    input wire logic normal_req,
    output logic fast_irq,
    output logic normal_irq
);
    // ==========================================================
    // Register state
    logic [1:0] nesting_control_r;
    logic [TRIG_W-1:0] ext_trigger_select_r;
    logic [BASEW-1:0] vector_base_r;
    logic [NSRC-1:0] fast_source_enable_r;
    logic [NLVL-1:0] fast_nesting_status_r;
    logic [NLVL-1:0] fast_nesting_status_nxt;
    logic [NEXT-1:0] ext_edge_clr;
    logic [NEXT-1:0] ext_req;
    logic [NSRC-1:0] all_req;
    logic [31:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic aw_held_r;
    logic w_held_r;
    logic wr_go;
    logic rd_go;
    reg_sel_t wr_sel;
    reg_sel_t rd_sel;
    pick_t pick;
    logic fast_nest_on;
    logic [31:0] vec_word;
    logic [31:0] wr_cur;
    logic [31:0] wr_word;

    // ==========================================================
    // Helpers
    function automatic reg_sel_t decode(input logic [31:0] addr);
        unique case (addr)
            OFS_NEST_CTRL: decode = REG_NEST_CTRL;
            OFS_TRIG_SEL: decode = REG_TRIG_SEL;
            OFS_EDGE_CLR: decode = REG_EDGE_CLR;
            OFS_FAST_VEC: decode = REG_FAST_VEC;
            OFS_FAST_STAT: decode = REG_FAST_STAT;
            OFS_VEC_BASE: decode = REG_VEC_BASE;
            OFS_FAST_EN: decode = REG_FAST_EN;
            default: decode = REG_NONE;
        endcase
    endfunction : decode

    // Lowest set bit, which is the highest priority level
    function automatic logic [NLVL-1:0] lowest_bit(input logic [NLVL-1:0] v);
        lowest_bit = v & (~v + {{(NLVL-1){1'b0}}, 1'b1});
    endfunction : lowest_bit

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] be);
        merge = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                merge[b*8 +: 8] = d[b*8 +: 8];
            end
        end
    endfunction : merge

    // ==========================================================
    // External inputs
    genvar gi;
    generate
        for (gi = 0; gi < NEXT; gi++) begin : g_ext
            ext_trigger u_trig (
                .aclk(aclk),
                .aresetn(aresetn),
                .pin(ext_int_in[gi]),
                .sel(trig_t'(ext_trigger_select_r[2*gi +: 2])),
                .edge_clr(ext_edge_clr[gi]),
                .req(ext_req[gi])
            );
        end
    endgenerate

    always_comb begin
        all_req = src_req;
        for (int e = 0; e < NEXT; e++) begin
            all_req[EXT_SRC_BASE + e] = src_req[EXT_SRC_BASE + e] | ext_req[e];
        end
    end

    // Edge clear bits skip bit 23
    always_comb begin
        ext_edge_clr = '0;
        if (wr_go && wr_sel == REG_EDGE_CLR) begin
            for (int e = 0; e < NEXT; e++) begin
                if (e < CLR_LO_N) begin
                    ext_edge_clr[e] = w_data_r[CLR_LO_LSB + e] & w_strb_r[(CLR_LO_LSB + e) / 8];
                end else begin
                    ext_edge_clr[e] = w_data_r[CLR_HI_LSB + e - CLR_LO_N]
                                      & w_strb_r[(CLR_HI_LSB + e - CLR_LO_N) / 8];
                end
            end
        end
    end

    // ==========================================================
    // Priority search
    assign fast_nest_on = nesting_control_r[FAST_NEST_BIT];

    always_comb begin
        logic [NLVL-1:0] blk_lowbit;
        logic allowed;
        allowed = 1'b0;
        blk_lowbit = lowest_bit(fast_nesting_status_r);
        pick = '0;
        for (int s = NSRC - 1; s >= 0; s--) begin
            // Blocked when some set level is at or above this source's priority
            allowed = !fast_nest_on || (blk_lowbit == '0)
                      || ((NLVL'(1) << src_prio[s]) < blk_lowbit);
            if (all_req[s] && fast_source_enable_r[s] && allowed) begin
                if (!pick.found || !fast_nest_on || src_prio[s] <= pick.lvl) begin
                    pick.found = 1'b1;
                    pick.idx = SRCW'(s);
                    pick.lvl = src_prio[s];
                end
            end
        end
    end

    always_comb begin
        vec_word = RST_WORD;
        vec_word[VEC_BASE_LSB +: BASEW] = vector_base_r;
        vec_word[VEC_IDX_LSB +: SRCW] = pick.idx;
    end

    // ==========================================================
    // AXI4-Lite write path
    assign wr_go = aw_held_r && w_held_r && !s_axil_bvalid;
    assign wr_sel = decode(aw_addr_r);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= RST_WORD;
            s_axil_awready <= 1'b0;
        end else if (s_axil_awvalid && s_axil_awready) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axil_awaddr;
            s_axil_awready <= 1'b0;
        end else if (wr_go) begin
            aw_held_r <= 1'b0;
        end else begin
            s_axil_awready <= !aw_held_r && !s_axil_bvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_r <= 1'b0;
            w_data_r <= RST_WORD;
            w_strb_r <= '0;
            s_axil_wready <= 1'b0;
        end else if (s_axil_wvalid && s_axil_wready) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axil_wdata;
            w_strb_r <= s_axil_wstrb;
            s_axil_wready <= 1'b0;
        end else if (wr_go) begin
            w_held_r <= 1'b0;
        end else begin
            s_axil_wready <= !w_held_r && !s_axil_bvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axil_bvalid <= 1'b0;
            s_axil_bresp <= RESP_OKAY;
        end else if (wr_go) begin
            s_axil_bvalid <= 1'b1;
            s_axil_bresp <= (wr_sel == REG_NONE || wr_sel == REG_FAST_VEC) ? RESP_DECERR : RESP_OKAY;
        end else if (s_axil_bready) begin
            s_axil_bvalid <= 1'b0;
        end
    end

    // ==========================================================
    // Control registers
    // Current word of the target, so a partial strobe keeps the other bytes
    always_comb begin
        unique case (wr_sel)
            REG_NEST_CTRL: wr_cur = {30'h0, nesting_control_r};
            REG_TRIG_SEL: wr_cur = {20'h0, ext_trigger_select_r};
            REG_VEC_BASE: wr_cur = {16'h0, vector_base_r};
            REG_FAST_EN: wr_cur = {4'h0, fast_source_enable_r};
            default: wr_cur = RST_WORD;
        endcase
        wr_word = merge(wr_cur, w_data_r, w_strb_r);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nesting_control_r <= '0;
        end else if (wr_go && wr_sel == REG_NEST_CTRL) begin
            nesting_control_r <= wr_word[FAST_NEST_BIT:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_trigger_select_r <= '0;
        end else if (wr_go && wr_sel == REG_TRIG_SEL) begin
            ext_trigger_select_r <= wr_word[TRIG_W-1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vector_base_r <= '0;
        end else if (wr_go && wr_sel == REG_VEC_BASE) begin
            vector_base_r <= wr_word[BASEW-1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fast_source_enable_r <= '0;
        end else if (wr_go && wr_sel == REG_FAST_EN) begin
            fast_source_enable_r <= wr_word[NSRC-1:0];
        end
    end

    // ==========================================================
    // Nesting status
    always_comb begin
        fast_nesting_status_nxt = fast_nesting_status_r;
        if (wr_go && wr_sel == REG_FAST_STAT && w_strb_r[0]) begin
            fast_nesting_status_nxt = fast_nesting_status_r & ~lowest_bit(fast_nesting_status_r);
        end
        // Setting wins over a clear in the same cycle
        if (rd_go && rd_sel == REG_FAST_VEC && fast_nest_on && pick.found) begin
            fast_nesting_status_nxt[pick.lvl] = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fast_nesting_status_r <= '0;
        end else begin
            fast_nesting_status_r <= fast_nesting_status_nxt;
        end
    end

    // ==========================================================
    // AXI4-Lite read path
    assign rd_go = s_axil_arvalid && s_axil_arready;
    assign rd_sel = decode(s_axil_araddr);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axil_arready <= 1'b0;
        end else begin
            s_axil_arready <= !rd_go && !s_axil_rvalid && !(s_axil_arready && s_axil_arvalid);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axil_rvalid <= 1'b0;
            s_axil_rdata <= RST_WORD;
            s_axil_rresp <= RESP_OKAY;
        end else if (rd_go) begin
            s_axil_rvalid <= 1'b1;
            s_axil_rresp <= (rd_sel == REG_NONE) ? RESP_DECERR : RESP_OKAY;
            unique case (rd_sel)
                REG_NEST_CTRL: s_axil_rdata <= {30'h0, nesting_control_r};
                REG_TRIG_SEL: s_axil_rdata <= {20'h0, ext_trigger_select_r};
                REG_FAST_VEC: s_axil_rdata <= vec_word;
                REG_FAST_STAT: s_axil_rdata <= {24'h0, fast_nesting_status_r};
                REG_VEC_BASE: s_axil_rdata <= {16'h0, vector_base_r};
                REG_FAST_EN: s_axil_rdata <= {4'h0, fast_source_enable_r};
                default: s_axil_rdata <= RST_WORD;
            endcase
        end else if (s_axil_rready) begin
            s_axil_rvalid <= 1'b0;
        end
    end

    // ==========================================================
    // Interrupt outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fast_irq <= 1'b0;
            normal_irq <= 1'b0;
        end else begin
            fast_irq <= pick.found;
            normal_irq <= normal_req && !pick.found;
        end
    end
endmodule : fiq_ctrl

// *** fiq_pkg.sv ***
// Purpose: Shared constants and types for the fast interrupt vector and external trigger block
// Assumes: AXI4-Lite slave, 32-bit data, full 32-bit byte addresses
// Notes: Offsets are byte addresses of aligned words
package fiq_pkg;
    localparam int NSRC = 28;
    localparam int NEXT = 6;
    localparam int NLVL = 8;
    localparam int SRCW = 5;
    localparam int PRIW = 3;
    localparam int BASEW = 16;

    // ==========================================================
    // Register map
    localparam logic [31:0] OFS_NEST_CTRL = 32'hffff0030;
    localparam logic [31:0] OFS_TRIG_SEL = 32'hffff0034;
    localparam logic [31:0] OFS_EDGE_CLR = 32'hffff0038;
    localparam logic [31:0] OFS_FAST_VEC = 32'hffff011c;
    localparam logic [31:0] OFS_FAST_STAT = 32'hffff013c;
    localparam logic [31:0] OFS_VEC_BASE = 32'hffff0140;
    localparam logic [31:0] OFS_FAST_EN = 32'hffff0144;

    // ==========================================================
    // Field positions
    localparam int FAST_NEST_BIT = 1;
    localparam int VEC_IDX_LSB = 2;
    localparam int VEC_BASE_LSB = 7;
    localparam int TRIG_W = 2 * NEXT;
    localparam int CLR_LO_LSB = 19;
    localparam int CLR_LO_N = 4;
    localparam int CLR_HI_LSB = 24;
    // Source index of external input 0; the others follow it
    localparam int EXT_SRC_BASE = 19;

    localparam logic [31:0] RST_WORD = 32'h00000000;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_DECERR = 2'b11;

    // ==========================================================
    // Trigger selections
    typedef enum logic [1:0] {
        TRIG_HIGH = 2'b00,
        TRIG_LOW = 2'b01,
        TRIG_RISE = 2'b10,
        TRIG_FALL = 2'b11
    } trig_t;

    typedef enum logic [2:0] {
        REG_NONE,
        REG_NEST_CTRL,
        REG_TRIG_SEL,
        REG_EDGE_CLR,
        REG_FAST_VEC,
        REG_FAST_STAT,
        REG_VEC_BASE,
        REG_FAST_EN
    } reg_sel_t;

    // Winner of the fast priority search
    typedef struct packed {
        logic found;
        logic [SRCW-1:0] idx;
        logic [PRIW-1:0] lvl;
    } pick_t;
endpackage : fiq_pkg

// *** ext_trigger.sv ***
// Purpose: One external interrupt input with selectable level or edge trigger
// Assumes: Pin is synchronous to aclk
// Notes: Latched edge stays until cleared by software
module ext_trigger
    import fiq_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic pin,
    input wire trig_t sel,
    input wire logic edge_clr,
    output logic req
);
    logic pin_prev_r;
    logic edge_r;
    logic edge_hit;

    always_comb begin
        unique case (sel)
            TRIG_RISE: edge_hit = pin & ~pin_prev_r;
            TRIG_FALL: edge_hit = ~pin & pin_prev_r;
            default: edge_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_prev_r <= 1'b0;
        end else begin
            pin_prev_r <= pin;
        end
    end

    // A new edge in the clear cycle survives
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            edge_r <= 1'b0;
        end else if (edge_hit) begin
            edge_r <= 1'b1;
        end else if (edge_clr) begin
            edge_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req <= 1'b0;
        end else begin
            unique case (sel)
                TRIG_HIGH: req <= pin;
                TRIG_LOW: req <= ~pin;
                TRIG_RISE, TRIG_FALL: req <= edge_r | edge_hit;
            endcase
        end
    end
endmodule : ext_trigger

// *** fiq_ctrl_props.sv ***
// Purpose: Bus and register format properties of the fast interrupt block
// Assumes: Sees only the ports of fiq_ctrl
// Notes: Read address is remembered to tell which register answers
module fiq_ctrl_props
    import fiq_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axil_araddr,
    input wire logic s_axil_arvalid,
    input wire logic s_axil_arready,
    input wire logic [31:0] s_axil_rdata,
    input wire logic [1:0] s_axil_rresp,
    input wire logic s_axil_rvalid,
    input wire logic s_axil_rready,
    input wire logic [1:0] s_axil_bresp,
    input wire logic s_axil_bvalid,
    input wire logic s_axil_bready,
    input wire logic normal_req,
    input wire logic fast_irq,
    input wire logic normal_irq
);
    logic [31:0] addr_r;

    always_ff @(posedge aclk) begin
        if (s_axil_arvalid && s_axil_arready) begin
            addr_r <= s_axil_araddr;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ==========================================================
    // Handshakes
    sequence s_ar_take;
        s_axil_arvalid && s_axil_arready;
    endsequence
    sequence s_b_done;
        s_axil_bvalid && s_axil_bready;
    endsequence
    sequence s_rd_of(logic [31:0] a);
        s_axil_rvalid && addr_r == a;
    endsequence

    a_read_answer: assert property (s_ar_take |=> s_axil_rvalid)
        else $error("read not answered one cycle after address");
    a_rdata_hold: assert property (s_axil_rvalid && !s_axil_rready |=> s_axil_rvalid && $stable(s_axil_rdata))
        else $error("read data dropped before rready");
    a_bresp_hold: assert property (s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid && $stable(s_axil_bresp))
        else $error("write response dropped before bready");
    a_b_release: assert property (s_b_done |=> !s_axil_bvalid)
        else $error("bvalid stays after accepted response");
    a_ar_refused: assert property (s_axil_rvalid |-> !s_axil_arready)
        else $error("read address taken while a read is answered");

    // ==========================================================
    // Register formats and interrupt outputs
    a_vec_format: assert property (s_rd_of(OFS_FAST_VEC) |->
        s_axil_rdata[31:23] == 9'h000 && s_axil_rdata[1:0] == 2'h0 && s_axil_rdata[6:2] < 5'h1c)
        else $error("fast vector word out of format");
    a_trig_resv: assert property (s_rd_of(OFS_TRIG_SEL) |-> s_axil_rdata[31:12] == 20'h00000)
        else $error("trigger select reserved bits set");
    a_clr_reads_zero: assert property (s_rd_of(OFS_EDGE_CLR) |-> s_axil_rdata == 32'h00000000)
        else $error("edge clear register reads nonzero");
    a_stat_resv: assert property (s_rd_of(OFS_FAST_STAT) |-> s_axil_rdata[31:8] == 24'h000000)
        else $error("nesting status reserved bits set");
    a_fast_first: assert property (normal_irq |-> !fast_irq)
        else $error("normal interrupt raised beside a fast one");
    a_normal_cause: assert property (normal_irq |-> $past(normal_req))
        else $error("normal interrupt without a request");
endmodule : fiq_ctrl_props

bind fiq_ctrl fiq_ctrl_props i_props (.aclk, .aresetn, .s_axil_araddr, .s_axil_arvalid, .s_axil_arready,
    .s_axil_rdata, .s_axil_rresp, .s_axil_rvalid, .s_axil_rready, .s_axil_bresp, .s_axil_bvalid,
    .s_axil_bready, .normal_req, .fast_irq, .normal_irq);

// *** ext_pins.sv ***
// Purpose: External interrupt pin drivers
// Assumes: Pins change just after a clock edge
// Notes: Pins are always driven, never released
module ext_pins (
    input wire logic aclk,
    output logic [5:0] ext_int_in = 6'h00
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] lvl_r = 6'h00;

    // Registered so a pin never moves inside the sampling step
    always @(posedge aclk) begin
        ext_int_in <= lvl_r;
    end

    task automatic set_pin(input int e, input logic v);
        lvl_r[e] <= v;
    endtask : set_pin
endmodule : ext_pins

// *** tb_top.sv ***
// Purpose: Self-checking bench of the fast interrupt block
// Assumes: AXI4-Lite master driven here, pins from ext_pins
// Notes: Priority of source i is i modulo 8
module tb_top;
    import fiq_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] VB = 32'h0052e180;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] s_axil_awaddr = 32'h0, s_axil_wdata = 32'h0, s_axil_araddr = 32'h0, s_axil_rdata;
    logic [3:0] s_axil_wstrb = 4'hf;
    logic s_axil_awvalid = 1'b0, s_axil_wvalid = 1'b0, s_axil_bready = 1'b0;
    logic s_axil_arvalid = 1'b0, s_axil_rready = 1'b0, normal_req = 1'b0;
    logic s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
    logic fast_irq, normal_irq;
    logic [1:0] s_axil_bresp, s_axil_rresp;
    logic [NSRC-1:0] src_req = 28'h0;
    logic [NSRC-1:0][PRIW-1:0] src_prio;
    logic [NEXT-1:0] ext_int_in;
    int err_count = 0;
    int checked = 0;
    int cycles = 0;

    fiq_ctrl i_fiq_ctrl (.aclk, .aresetn, .s_axil_awaddr, .s_axil_awvalid, .s_axil_awready, .s_axil_wdata,
        .s_axil_wstrb, .s_axil_wvalid, .s_axil_wready, .s_axil_bresp, .s_axil_bvalid, .s_axil_bready,
        .s_axil_araddr, .s_axil_arvalid, .s_axil_arready, .s_axil_rdata, .s_axil_rresp, .s_axil_rvalid,
        .s_axil_rready, .src_req, .src_prio, .ext_int_in, .normal_req, .fast_irq, .normal_irq);
    ext_pins u_pins (.aclk, .ext_int_in);

    initial begin
        forever #20 aclk = ~aclk;
    end

    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            complete_run();
        end
    end

    // ==========================================================
    // Shared tasks
    task automatic complete_run;
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            $display("BAD %s exp %h seen %h", nm, exp, got);
            err_count++;
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask : cyc

    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        bit done;
        done = 1'b0;
        @(posedge aclk);
        s_axil_awaddr <= a;
        s_axil_wdata <= d;
        s_axil_awvalid <= 1'b1;
        s_axil_wvalid <= 1'b1;
        s_axil_bready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (s_axil_awvalid && s_axil_awready) begin
                s_axil_awvalid <= 1'b0;
                s_axil_awaddr <= ~a;
            end
            if (s_axil_wvalid && s_axil_wready) begin
                s_axil_wvalid <= 1'b0;
                s_axil_wdata <= ~d;
            end
            if (s_axil_bvalid) begin
                s_axil_bready <= 1'b0;
                chk("bresp", {30'h0, s_axil_bresp}, {30'h0, er});
                done = 1'b1;
            end
        end
    endtask : wr

    task automatic rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
        bit done;
        done = 1'b0;
        @(posedge aclk);
        s_axil_araddr <= a;
        s_axil_arvalid <= 1'b1;
        s_axil_rready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (s_axil_arvalid && s_axil_arready) begin
                s_axil_arvalid <= 1'b0;
                s_axil_araddr <= ~a;
            end
            if (s_axil_rvalid) begin
                s_axil_rready <= 1'b0;
                chk("rresp", {30'h0, s_axil_rresp}, {30'h0, er});
                if (er == RESP_OKAY) begin
                    chk("rdata", s_axil_rdata, ed);
                end
                done = 1'b1;
            end
        end
    endtask : rd

    // ==========================================================
    // Scenarios
    task automatic t_reset;
        rd(OFS_TRIG_SEL, 32'h0, RESP_OKAY);
        rd(OFS_FAST_STAT, 32'h0, RESP_OKAY);
        rd(OFS_EDGE_CLR, 32'h0, RESP_OKAY);
        wr(OFS_FAST_VEC, 32'hffffffff, RESP_DECERR);
        rd(OFS_FAST_VEC, 32'h0, RESP_OKAY);
        rd(32'hffff0100, 32'h0, RESP_DECERR);
        chk("fiq_rst", fast_irq, 32'h0);
    endtask : t_reset

    task automatic t_trig;
        logic [1:0] m;
        logic [31:0] sel;
        int cb;
        sel = 32'h0;
        wr(OFS_FAST_EN, 32'h01f80000, RESP_OKAY);
        for (int e = 0; e < NEXT; e++) begin
            m = 2'(e % 4);
            cb = (e < 4) ? 19 + e : 20 + e;
            sel = sel | (32'(m) << (2 * e));
            u_pins.set_pin(e, m[0]);
            wr(OFS_TRIG_SEL, sel, RESP_OKAY);
            rd(OFS_TRIG_SEL, sel, RESP_OKAY);
            wr(OFS_EDGE_CLR, 32'h1 << cb, RESP_OKAY);
            cyc(3);
            chk("idle", fast_irq, 32'h0);
            u_pins.set_pin(e, !m[0]);
            cyc(4);
            chk("active", fast_irq, 32'h1);
            u_pins.set_pin(e, m[0]);
            cyc(4);
            chk("held", fast_irq, {31'h0, m[1]});
            wr(OFS_EDGE_CLR, 32'h1 << cb, RESP_OKAY);
            cyc(3);
            chk("cleared", fast_irq, 32'h0);
        end
    endtask : t_trig

    task automatic t_nest;
        wr(OFS_VEC_BASE, 32'h0000a5c3, RESP_OKAY);
        wr(OFS_FAST_EN, 32'h00000009, RESP_OKAY);
        wr(OFS_NEST_CTRL, 32'h2, RESP_OKAY);
        src_req[3] <= 1'b1;
        cyc(3);
        chk("fiq3", fast_irq, 32'h1);
        rd(OFS_FAST_VEC, VB | 32'h0c, RESP_OKAY);
        rd(OFS_FAST_STAT, 32'h08, RESP_OKAY);
        cyc(3);
        chk("blocked", fast_irq, 32'h0);
        wr(OFS_NEST_CTRL, 32'h0, RESP_OKAY);
        cyc(3);
        chk("unnested", fast_irq, 32'h1);
        wr(OFS_NEST_CTRL, 32'h2, RESP_OKAY);
        src_req[0] <= 1'b1;
        cyc(3);
        chk("fiq0", fast_irq, 32'h1);
        rd(OFS_FAST_VEC, VB, RESP_OKAY);
        rd(OFS_FAST_STAT, 32'h09, RESP_OKAY);
        wr(OFS_FAST_STAT, 32'hff, RESP_OKAY);
        rd(OFS_FAST_STAT, 32'h08, RESP_OKAY);
        wr(OFS_FAST_STAT, 32'hff, RESP_OKAY);
        rd(OFS_FAST_STAT, 32'h00, RESP_OKAY);
        wr(OFS_NEST_CTRL, 32'h0, RESP_OKAY);
        src_req <= 28'h0;
    endtask : t_nest

    task automatic t_normal;
        normal_req <= 1'b1;
        cyc(3);
        chk("nirq", normal_irq, 32'h1);
        src_req[0] <= 1'b1;
        cyc(3);
        chk("nirq_fast", normal_irq, 32'h0);
        chk("fiq_win", fast_irq, 32'h1);
        normal_req <= 1'b0;
        src_req <= 28'h0;
    endtask : t_normal

    initial begin
        for (int i = 0; i < NSRC; i++) begin
            src_prio[i] <= 3'(i % 8);
        end
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_trig();
        t_nest();
        t_normal();
        complete_run();
    end
endmodule : tb_top
